/* File: t0_apdu_pkg.sv */
/*
  shared types and constants for the card-side command sequencer
  assumes: byte-wide character link handled elsewhere (framing, parity)
*/
package t0_apdu_pkg;

  localparam logic [7:0] SW1_MORE     = 8'h61;
  localparam logic [7:0] SW1_WRONG_LE = 8'h6C;
  localparam logic [7:0] SW1_OK       = 8'h90;
  localparam logic [7:0] SW2_OK       = 8'h00;
  localparam logic [7:0] SW1_WARN     = 8'h62;
  localparam logic [7:0] INS_GET_RESP = 8'hC0;
  localparam logic [7:0] ACK_NONE     = 8'h00;

  typedef enum logic [1:0] {
    CASE_1,
    CASE_2,
    CASE_3,
    CASE_4
  } apdu_case_e;

  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } hdr_s;

  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
  } sw_s;

  typedef struct packed {
    logic       has_cmd_data;
    logic       has_resp_data;
  } cmd_class_s;

endpackage

/* File: t0_case2_pace.sv */
/*
  decides the reply to a case 2 style header from Le and available length
  assumes: avail is the length the application holds, buf_max the card buffer limit
*/
`timescale 1ns/1ps
module t0_case2_pace (
  input  wire logic                  fault,
  input  wire logic [7:0]            le,
  input  wire logic [8:0]            avail,
  input  wire logic [7:0]            buf_max,
  input  wire t0_apdu_pkg::sw_s      err_sw,
  output logic                       send_data,
  output logic [7:0]                 send_len,
  output t0_apdu_pkg::sw_s           trailer
);

  wire le_zero  = (le == 8'h00);
  wire le_over  = ({1'b0, le} > avail);
  wire le_under = ({1'b0, le} < avail);
  wire buf_short = ({1'b0, buf_max} < avail);
  wire [7:0] avail_b = (avail > 9'h0FF) ? 8'hFF : avail[7:0];
  wire [8:0] rest    = avail - {1'b0, le};
  wire [7:0] rest_b  = (rest > 9'h0FF) ? 8'h00 : rest[7:0];

  always_comb begin
    send_data = 1'b0;
    send_len  = 8'h00;
    trailer   = err_sw;
    if (fault || avail == 9'h000) begin
      trailer = err_sw;                                    // [R7] [R19]
    end else if (le_zero || le_over) begin
      trailer = '{sw1: t0_apdu_pkg::SW1_WRONG_LE, sw2: avail_b};  // [R19]
    end else if (le_under) begin
      send_data = 1'b1;
      send_len  = le;
      trailer   = '{sw1: t0_apdu_pkg::SW1_MORE, sw2: rest_b};      // [R21]
    end else if (buf_short) begin
      trailer = '{sw1: t0_apdu_pkg::SW1_MORE, sw2: buf_max};       // [R20]
    end else begin
      send_data = 1'b1;
      send_len  = le;
      trailer   = '{sw1: t0_apdu_pkg::SW1_OK, sw2: t0_apdu_pkg::SW2_OK}; // [R20]
    end
  end

endmodule

/* File: t0_apdu_card.sv */
/*
  card-side transport sequencer for character-oriented APDU exchange:
  takes headers and command data bytes, hands commands to the application,
  and returns response data and the two-byte trailer or procedure bytes.
  assumes: link layer delivers whole bytes with valid strobes and accepts
  bytes with ready; application answers each command with done/ok/avail.
*/
// Functional notes
// R1: terminal swallows 61/6C, never forwards them
// R2: other status ends terminal command
// R3: case 4 warnings keep terminal going
// R4: status always describes latest command
// R5: case 1 header carries P3 zero
// R6: P3 zero: pick case 1 or 2
// R7: case 2 returns data then status
// R8: terminal maps data and status unchanged
// R9: case 3 Lc is 1 to 255
// R10: terminal sends data after procedure byte
// R11: case 3 status after all data
// R12: terminal drops Le from case 4
// R13: case 4 data answered by 61xx
// R14: terminal GET RESPONSE P3 at most xx
// R15: case 4 warning leads GET RESPONSE zero
// R16: case 4 GET RESPONSE handled as case 2
// R17: terminal resends header on 6Cxx
// R18: 61/6C only for case 2 and 4
// R19: Le zero or too big gives 6C
// R20: Le equal returns data then status; code answers 61 with BUF_MAX and no data when avail exceeds BUF_MAX
// R21: Le short returns data then 61xx
// R22: case 4 gives 61xx or error
// R23: terminal classifies answer by first byte
`timescale 1ns/1ps
module t0_apdu_card #(
  parameter int          HDR_BYTES = 5,
  parameter logic [7:0]  BUF_MAX   = 8'hFF
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              rx_byte,
  input  wire logic                    rx_valid,
  output logic [7:0]                   tx_byte,
  output logic                         tx_valid,
  input  wire logic                    tx_ready,
  output t0_apdu_pkg::hdr_s            cmd_hdr,
  output logic                         cmd_start,
  output logic [7:0]                   cmd_data,
  output logic                         cmd_data_valid,
  input  wire t0_apdu_pkg::cmd_class_s cmd_class,
  input  wire logic                    app_done,
  input  wire logic                    app_ok,
  input  wire t0_apdu_pkg::sw_s        app_sw,
  input  wire logic [8:0]              app_avail,
  input  wire logic [7:0]              app_rd_data,
  output logic [7:0]                   app_rd_addr
);

  typedef enum logic [3:0] {
    ST_HDR,
    ST_CLASSIFY,
    ST_ACK,
    ST_DATA_IN,
    ST_WAIT_APP,
    ST_DECIDE,
    ST_ACK_OUT,
    ST_DATA_OUT,
    ST_SW1,
    ST_SW2
  } state_e;

  state_e                 state_r, state_nxt;
  t0_apdu_pkg::hdr_s      hdr_r;
  logic [2:0]             hcnt_r;
  logic [7:0]             dcnt_r;
  logic [8:0]             pend_r;
  logic [7:0]             pend_off_r;
  logic                   c4_pending_r;
  t0_apdu_pkg::apdu_case_e case_r;
  t0_apdu_pkg::sw_s       sw_r;
  logic [7:0]             out_len_r;
  logic                   app_ok_r;
  t0_apdu_pkg::sw_s       app_sw_r;

  function automatic t0_apdu_pkg::sw_s non_ok(input t0_apdu_pkg::sw_s s);
    // an error slot must never carry the normal-completion code
    if (s.sw1 == t0_apdu_pkg::SW1_OK && s.sw2 == t0_apdu_pkg::SW2_OK)
      non_ok = '{sw1: t0_apdu_pkg::SW1_WARN, sw2: 8'h00};
    else
      non_ok = s;
  endfunction

  wire is_get_resp = (hdr_r.ins == t0_apdu_pkg::INS_GET_RESP);
  wire hdr_last    = rx_valid && (hcnt_r == 3'(HDR_BYTES - 1));
  wire data_last   = rx_valid && (dcnt_r == hdr_r.p3 - 8'h01);
  wire tx_fire     = tx_valid && tx_ready;
  // P3 zero with no response data declared means case 1, else case 2 wants all
  wire p3_zero     = (hdr_r.p3 == 8'h00);
  wire wants_data  = cmd_class.has_cmd_data && !p3_zero;

  wire                    pace_send;
  wire [7:0]              pace_len;
  t0_apdu_pkg::sw_s       pace_sw;

  t0_case2_pace u_pace (
    .fault     (!app_ok_r),
    .le        (hdr_r.p3),
    .avail     (is_get_resp ? pend_r : app_avail),
    .buf_max   (BUF_MAX),
    .err_sw    (non_ok(app_sw_r)),
    .send_data (pace_send),
    .send_len  (pace_len),
    .trailer   (pace_sw)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_HDR:      if (hdr_last) state_nxt = ST_CLASSIFY;
      ST_CLASSIFY: begin
        if (is_get_resp)
          state_nxt = ST_DECIDE;
        else if (wants_data)
          state_nxt = ST_ACK;
        else
          state_nxt = ST_WAIT_APP;
      end
      ST_ACK:      if (tx_fire) state_nxt = ST_DATA_IN;
      ST_DATA_IN:  if (data_last) state_nxt = ST_WAIT_APP;         // [R11]
      ST_WAIT_APP: if (app_done) state_nxt = ST_DECIDE;
      ST_DECIDE:   state_nxt = (case_r == t0_apdu_pkg::CASE_2 && pace_send) ?
                               ST_ACK_OUT : ST_SW1;
      ST_ACK_OUT:  if (tx_fire) state_nxt = ST_DATA_OUT;
      ST_DATA_OUT: if (tx_fire && dcnt_r == out_len_r - 8'h01) state_nxt = ST_SW1;
      ST_SW1:      if (tx_fire) state_nxt = ST_SW2;
      ST_SW2:      if (tx_fire) state_nxt = ST_HDR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_HDR;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hdr_r  <= '0;
      hcnt_r <= 3'h0;
    end else if (state_r == ST_HDR && rx_valid) begin
      hdr_r  <= {hdr_r[31:0], rx_byte};
      hcnt_r <= hdr_last ? 3'h0 : hcnt_r + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      case_r <= t0_apdu_pkg::CASE_1;
    end else if (state_r == ST_CLASSIFY) begin
      if (is_get_resp)
        case_r <= t0_apdu_pkg::CASE_2;                             // [R16]
      else if (wants_data)
        case_r <= cmd_class.has_resp_data ? t0_apdu_pkg::CASE_4 : t0_apdu_pkg::CASE_3;
      else if (cmd_class.has_resp_data)
        case_r <= t0_apdu_pkg::CASE_2;                             // [R6]
      else
        case_r <= t0_apdu_pkg::CASE_1;                             // [R6]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dcnt_r <= 8'h00;
    end else if (state_r == ST_DECIDE || state_r == ST_CLASSIFY) begin
      dcnt_r <= 8'h00;
    end else if ((state_r == ST_DATA_IN && rx_valid) || (state_r == ST_DATA_OUT && tx_fire)) begin
      dcnt_r <= dcnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      app_ok_r <= 1'b0;
      app_sw_r <= '0;
    end else if (state_r == ST_WAIT_APP && app_done) begin
      app_ok_r <= app_ok;
      app_sw_r <= app_sw;
    end else if (state_r == ST_CLASSIFY && is_get_resp) begin
      // retrieval proceeds only when something is left to fetch
      app_ok_r <= c4_pending_r;
      app_sw_r <= '{sw1: 8'h6F, sw2: 8'h00};
    end
  end

  // decide the trailer; status always belongs to the command just taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_r         <= '0;
      out_len_r    <= 8'h00;
      pend_r       <= 9'h000;
      pend_off_r   <= 8'h00;
      c4_pending_r <= 1'b0;
    end else if (state_r == ST_DECIDE) begin
      out_len_r <= pace_len;
      unique case (case_r)
        t0_apdu_pkg::CASE_1, t0_apdu_pkg::CASE_3: begin
          sw_r         <= app_sw_r;                                 // [R4] [R18]
          c4_pending_r <= 1'b0;
        end
        t0_apdu_pkg::CASE_4: begin
          if (app_ok_r && app_avail != 9'h000) begin
            sw_r <= '{sw1: t0_apdu_pkg::SW1_MORE,
                      sw2: (app_avail > 9'h0FF) ? 8'h00 : app_avail[7:0]}; // [R13] [R22]
            pend_r       <= app_avail;
            pend_off_r   <= 8'h00;
            c4_pending_r <= 1'b1;
          end else begin
            sw_r         <= non_ok(app_sw_r);                       // [R13] [R22]
            c4_pending_r <= 1'b0;
          end
        end
        t0_apdu_pkg::CASE_2: begin
          sw_r <= pace_sw;                                           // [R7] [R4]
          if (!is_get_resp) begin
            pend_r     <= app_avail;
            pend_off_r <= 8'h00;
          end
          if (pace_send) begin
            pend_r     <= (is_get_resp ? pend_r : app_avail) - {1'b0, pace_len};
            pend_off_r <= (is_get_resp ? pend_off_r : 8'h00) + pace_len;
          end
          // a 61 with no data sent still leaves the whole run to fetch
          c4_pending_r <= (pace_sw.sw1 == t0_apdu_pkg::SW1_MORE);          // [R20] [R21]
        end
      endcase
    end
  end

  // data leaves before status; read address walks the pending window
  assign app_rd_addr = pend_off_r - out_len_r + dcnt_r;

  always_comb begin
    tx_valid = 1'b0;
    tx_byte  = 8'h00;
    unique case (state_r)
      ST_ACK, ST_ACK_OUT: begin
        tx_valid = 1'b1;
        tx_byte  = hdr_r.ins;
      end
      ST_DATA_OUT: begin
        tx_valid = 1'b1;
        tx_byte  = app_rd_data;                                      // [R20] [R21]
      end
      ST_SW1: begin
        tx_valid = 1'b1;
        tx_byte  = sw_r.sw1;
      end
      ST_SW2: begin
        tx_valid = 1'b1;
        tx_byte  = sw_r.sw2;
      end
      default: begin
        tx_valid = 1'b0;
        tx_byte  = t0_apdu_pkg::ACK_NONE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_start      <= 1'b0;
      cmd_data_valid <= 1'b0;
      cmd_data       <= 8'h00;
      cmd_hdr        <= '0;
    end else begin
      cmd_start      <= (state_r == ST_CLASSIFY) && !is_get_resp;
      cmd_data_valid <= (state_r == ST_DATA_IN) && rx_valid;
      if (state_r == ST_DATA_IN && rx_valid)
        cmd_data <= rx_byte;
      if (state_r == ST_CLASSIFY)
        cmd_hdr <= hdr_r;
    end
  end

  property p_case3_status_after_data;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_DATA_IN && !(rx_valid && dcnt_r == hdr_r.p3 - 8'h01))
      |=> (state_r == ST_DATA_IN);
  endproperty
  a_case3_status_after_data: assert property (p_case3_status_after_data) // [R11]
    else $error("status sent while command data still arriving");

  property p_no_6c_for_case1;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_SW1 && (case_r == t0_apdu_pkg::CASE_1 || case_r == t0_apdu_pkg::CASE_3))
      |-> (sw_r.sw1 != t0_apdu_pkg::SW1_MORE && sw_r.sw1 != t0_apdu_pkg::SW1_WRONG_LE);
  endproperty
  a_no_6c_for_case1: assert property (p_no_6c_for_case1) // [R18]
    else $error("procedure byte on a case 1 or 3 command");

  property p_case4_ok_gives_61;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_DECIDE && case_r == t0_apdu_pkg::CASE_4 && app_ok_r && app_avail != 9'h000)
      |=> (sw_r.sw1 == t0_apdu_pkg::SW1_MORE);
  endproperty
  a_case4_ok_gives_61: assert property (p_case4_ok_gives_61) // [R13]
    else $error("case 4 normal processing did not give 61");

  property p_error_never_9000;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_DECIDE && !app_ok_r && case_r != t0_apdu_pkg::CASE_1
       && case_r != t0_apdu_pkg::CASE_3)
      |=> !(sw_r.sw1 == t0_apdu_pkg::SW1_OK && sw_r.sw2 == t0_apdu_pkg::SW2_OK);
  endproperty
  a_error_never_9000: assert property (p_error_never_9000) // [R22]
    else $error("error path returned normal completion");

  property p_le_zero_gives_6c;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_DECIDE && case_r == t0_apdu_pkg::CASE_2 && app_ok_r
       && hdr_r.p3 == 8'h00 && !is_get_resp && app_avail != 9'h000)
      |=> (sw_r.sw1 == t0_apdu_pkg::SW1_WRONG_LE && state_r == ST_SW1);
  endproperty
  a_le_zero_gives_6c: assert property (p_le_zero_gives_6c) // [R19]
    else $error("Le zero did not yield 6C");

  sequence s_data_out;
    (state_r == ST_DATA_OUT) ##1 (state_r == ST_DATA_OUT || state_r == ST_SW1);
  endsequence
  property p_data_before_status;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_ACK_OUT && tx_fire) |=> s_data_out;
  endproperty
  a_data_before_status: assert property (p_data_before_status) // [R20]
    else $error("data not followed by status");

  property p_short_le_61;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_DECIDE && case_r == t0_apdu_pkg::CASE_2 && pace_send
       && pace_sw.sw1 == t0_apdu_pkg::SW1_MORE) |=> c4_pending_r;
  endproperty
  a_short_le_61: assert property (p_short_le_61) // [R21]
    else $error("remainder not kept after 61");

  property p_get_resp_as_case2;
    @(posedge mclk) disable iff (sys_rst)
      (state_r == ST_CLASSIFY && is_get_resp) |=> (case_r == t0_apdu_pkg::CASE_2);
  endproperty
  a_get_resp_as_case2: assert property (p_get_resp_as_case2) // [R16]
    else $error("retrieval command not handled as case 2");

endmodule

/* File: t0_term_model.sv */
/*
  terminal transport model on the far side of the card sequencer link
  assumes: the card takes one byte per rx_valid pulse and holds tx_valid until tx_ready
*/
`timescale 1ns/1ps
module t0_term_model (
  input  wire logic       mclk,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  input  wire logic [3:0] stall,
  output logic            tx_ready,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            timed_out
);
  logic [7:0]       resp [0:255];
  int               nrx;
  t0_apdu_pkg::sw_s first_sw;

  initial begin
    tx_ready  = 1'b0;
    rx_valid  = 1'b0;
    rx_byte   = 8'h00;
    timed_out = 1'b0;
  end

  // a slow terminal holds off tx_ready for stall cycles
  task automatic get_byte(output logic [7:0] b);
    int n = 0;
    b = 8'hXX;
    do begin
      @(posedge mclk);
      n++;
    end while (tx_valid !== 1'b1 && n < 400);
    if (tx_valid !== 1'b1) timed_out <= 1'b1;
    else begin
      repeat (stall) @(posedge mclk);
      tx_ready <= 1'b1;
      @(posedge mclk);
      b = tx_byte;
      tx_ready <= 1'b0;
    end
  endtask

  // idle line shows the inverse of the last byte, never a stale copy
  task automatic put_byte(input logic [7:0] b);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
    @(posedge mclk);
  endtask

  // h.p3 carries Lc for cases 3 and 4; Le is never sent for case 4
  task automatic exchange(input t0_apdu_pkg::hdr_s h, input t0_apdu_pkg::apdu_case_e cs,
                          output t0_apdu_pkg::sw_s sw);
    t0_apdu_pkg::hdr_s cur;
    logic [7:0]        b, s2;
    logic              dout, sent;
    cur = h;
    nrx = 0;
    first_sw = 16'h0000;
    sw = 16'hFFFF;
    dout = (cs == t0_apdu_pkg::CASE_3 || cs == t0_apdu_pkg::CASE_4);
    if (cs == t0_apdu_pkg::CASE_1) cur.p3 = 8'h00;
    for (int r = 0; r < 8 && !timed_out; r++) begin
      for (int i = 4; i >= 0; i--) put_byte(cur[i*8 +: 8]);
      sent = 1'b0;
      get_byte(b);
      if (b === cur.ins) begin
        for (int i = 0; i < cur.p3; i++) begin
          if (dout) put_byte(8'hD0 + i[7:0]);
          else begin
            get_byte(resp[nrx]);
            nrx++;
          end
        end
        sent = dout;
        dout = 1'b0;
        get_byte(b);
      end
      get_byte(s2);
      if (first_sw === 16'h0000) first_sw = {b, s2};
      if (b === t0_apdu_pkg::SW1_MORE)
        cur = {h.cla, t0_apdu_pkg::INS_GET_RESP, 16'h0000, s2};
      else if (b === t0_apdu_pkg::SW1_WRONG_LE)
        cur.p3 = s2;
      else if (sent && cs == t0_apdu_pkg::CASE_4 && (b === 8'h62 || b === 8'h63 ||
               (b[7:4] === 4'h9 && {b, s2} !== 16'h9000)))
        cur = {h.cla, t0_apdu_pkg::INS_GET_RESP, 24'h000000};
      else begin
        sw = {b, s2};
        break;
      end
    end
  endtask
endmodule

/* File: t0_apdu_transport_tb.sv */
/*
  self-checking bench: terminal model on the link, small application model
  assumes: package, card sequencer and terminal model compiled first
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); \
  end \
end
module t0_apdu_transport_tb;
  logic                    mclk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic [7:0]              rx_byte, tx_byte, cmd_data, app_rd_addr;
  logic                    rx_valid, tx_valid, tx_ready, cmd_start, cmd_data_valid, hung;
  logic                    app_done = 1'b0;
  logic                    app_ok = 1'b1;
  logic [3:0]              stall = 4'h0;
  logic [8:0]              app_avail = 9'h000;
  t0_apdu_pkg::hdr_s       cmd_hdr;
  t0_apdu_pkg::cmd_class_s cmd_class = 2'b00;
  t0_apdu_pkg::sw_s        app_sw = 16'h9000;
  t0_apdu_pkg::sw_s        fin;
  logic [7:0]              rxd [0:15];
  int                      want = -1;
  int                      dcount = 0;
  int                      errors = 0;
  int                      comparisons = 0;
  wire  [7:0]              app_rd_data = app_rd_addr + 8'h30;

  always #2.5 mclk = ~mclk;

  // small buffer limit forces split retrieval on runs longer than 4 bytes
  t0_apdu_card #(.HDR_BYTES(5), .BUF_MAX(8'h04)) t0_apdu_card_inst (
    .mclk(mclk), .sys_rst(sys_rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_hdr(cmd_hdr),
    .cmd_start(cmd_start), .cmd_data(cmd_data), .cmd_data_valid(cmd_data_valid),
    .cmd_class(cmd_class), .app_done(app_done), .app_ok(app_ok), .app_sw(app_sw),
    .app_avail(app_avail), .app_rd_data(app_rd_data), .app_rd_addr(app_rd_addr));

  t0_term_model t0_term_model_inst (
    .mclk(mclk), .tx_byte(tx_byte), .tx_valid(tx_valid), .stall(stall),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .timed_out(hung));

  // application: finishes once all command data has arrived
  always @(posedge mclk) begin
    app_done <= 1'b0;
    if (cmd_start === 1'b1) begin
      dcount <= 0;
      want   <= cmd_class.has_cmd_data ? int'(cmd_hdr.p3) : 0;
    end else if (want >= 0) begin
      if (cmd_data_valid === 1'b1) begin
        rxd[dcount[3:0]] <= cmd_data;
        dcount <= dcount + 1;
      end
      if (dcount == want) begin
        app_done <= 1'b1;
        want <= -1;
      end
    end
  end

  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    if (hung === 1'b1) begin
      errors++;
      complete_run();
    end
  end

  task automatic run(input logic [39:0] h, input t0_apdu_pkg::apdu_case_e cs,
                     input logic [1:0] cls, input logic ok, input logic [15:0] sw,
                     input logic [8:0] avail, input logic [3:0] slow);
    @(posedge mclk);
    cmd_class <= cls;
    app_ok    <= ok;
    app_sw    <= sw;
    app_avail <= avail;
    stall     <= slow;
    t0_term_model_inst.exchange(h, cs, fin);
  endtask

  task automatic chk_resp(input logic [15:0] first, input int n, input logic [15:0] last);
    `CHK("first answer", first, t0_term_model_inst.first_sw)
    `CHK("data count", n, t0_term_model_inst.nrx)
    `CHK("status", last, fin)
    for (int i = 0; i < n; i++)
      `CHK("data", 8'h30 + i[7:0], t0_term_model_inst.resp[i])
  endtask

  task automatic s_case1();
    run(40'h8010000007, t0_apdu_pkg::CASE_1, 2'b00, 1'b1, 16'h9000, 9'h003, 4'h0);
    chk_resp(16'h9000, 0, 16'h9000);
  endtask

  task automatic s_case2_all();
    run(40'h80B0000000, t0_apdu_pkg::CASE_2, 2'b01, 1'b1, 16'h9000, 9'h003, 4'h2);
    chk_resp(16'h6C03, 3, 16'h9000);
  endtask

  task automatic s_case2_over();
    run(40'h80B0000005, t0_apdu_pkg::CASE_2, 2'b01, 1'b1, 16'h9000, 9'h003, 4'h0);
    chk_resp(16'h6C03, 3, 16'h9000);
  endtask

  task automatic s_case2_short();
    run(40'h80B0000002, t0_apdu_pkg::CASE_2, 2'b01, 1'b1, 16'h9000, 9'h004, 4'h0);
    chk_resp(16'h6102, 4, 16'h9000);
  endtask

  task automatic s_case2_buf();
    run(40'h80B0000006, t0_apdu_pkg::CASE_2, 2'b01, 1'b1, 16'h9000, 9'h006, 4'h1);
    chk_resp(16'h6104, 6, 16'h9000);
  endtask

  task automatic s_case2_err();
    run(40'h80B0000003, t0_apdu_pkg::CASE_2, 2'b01, 1'b0, 16'h6A82, 9'h003, 4'h0);
    chk_resp(16'h6A82, 0, 16'h6A82);
  endtask

  task automatic s_case3();
    run(40'h80D6000003, t0_apdu_pkg::CASE_3, 2'b10, 1'b1, 16'h9000, 9'h000, 4'h0);
    chk_resp(16'h9000, 0, 16'h9000);
    `CHK("cmd bytes", 3, dcount)
    `CHK("cmd header", 40'h80D6000003, cmd_hdr)
    for (int i = 0; i < 3; i++)
      `CHK("cmd data", 8'hD0 + i[7:0], rxd[i])
  endtask

  task automatic s_case4();
    run(40'h8088000002, t0_apdu_pkg::CASE_4, 2'b11, 1'b1, 16'h9000, 9'h003, 4'h0);
    chk_resp(16'h6103, 3, 16'h9000);
  endtask

  task automatic s_case4_err();
    run(40'h8088000001, t0_apdu_pkg::CASE_4, 2'b11, 1'b0, 16'h6281, 9'h000, 4'h0);
    `CHK("first answer", 16'h6281, t0_term_model_inst.first_sw)
    `CHK("final not ok", 1'b1, fin !== 16'h9000)
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    s_case1();
    s_case2_all();
    s_case2_over();
    s_case2_short();
    s_case2_buf();
    s_case2_err();
    s_case3();
    s_case4();
    s_case4_err();
    complete_run();
  end
endmodule
